// >>> core/los_pkg.sv
// Constants, field layouts and carrier types of the loss-of-signal
// supervisor. Shared by the design and by whoever drives its ports.
package los_pkg;

	// ==========================================================
	// Register map: word index = {channel, register}
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CFG_W = 5;
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_DET_CFG = 2'h1;
	localparam logic [1:0] REG_RX_CFG = 2'h2;
	localparam logic [1:0] REG_LINE_MODE = 2'h3;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

	// ==========================================================
	// Alarm status fields
	localparam int ST_LOL = 4;
	localparam int ST_LOS = 3;
	localparam int ST_ALOS = 2;
	localparam int ST_DLOS = 1;
	localparam int ST_DMO = 0;

	// ==========================================================
	// Detector configuration fields
	localparam int DET_BYPASS = 3;
	localparam int DET_ADIS = 2;
	localparam int DET_DDIS = 1;
	localparam int DET_EQ = 0;

	// ==========================================================
	// Receive configuration fields
	localparam int RX_SINGLE = 4;
	localparam int RX_MUTE = 3;
	localparam int RX_OFF = 2;
	localparam int RX_INV = 1;

	// ==========================================================
	// Detector timing, in unit intervals of the recovered clock
	localparam int E3_LOS_UI_DEF = 32;
	localparam int E3_LOS_UI_MIN = 10;
	localparam int E3_LOS_UI_MAX = 255;
	localparam int ZERO_RUN = 160;
	localparam int WIN_BITS = 32;
	localparam int WIN_ONES = 10;
	localparam int WIN_PASS = 4;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_E3,
		MODE_DS3,
		MODE_STS1
	} line_mode_t;

	typedef enum logic {
		DIG_CLEAR,
		DIG_LOSS
	} dig_state_t;

	// Pins from the analog front end and recovery PLL, one channel
	typedef struct packed {
		logic line_clk;
		logic pos;
		logic neg;
		logic amp_low;
		logic amp_high;
		logic loss_of_lock;
		logic drive_mon;
	} line_in_t;

	// Recovered data and clock toward the terminal equipment
	typedef struct packed {
		logic positive_rail_data_out;
		logic negative_rail_data_out;
		logic recovered_clock_out;
	} rx_out_t;

	// Threshold choice handed to the amplitude comparators
	typedef struct packed {
		logic sts1;
		logic eq_on;
		logic thr_pin;
	} thr_sel_t;

endpackage

// >>> core/los_monitor_mute.sv
// Three-channel loss-of-signal supervisor with mute and rail formatting.
// Assumes front-end comparators and a recovered line clock arriving
// asynchronously; everything is sampled by clk_sys, much faster than it.
//
// Overview of operation
// - E3 declares at or below -35dB amplitude, clears at -15dB or more.
// - E3 declaration comes 10 to 255 UI after signal disappears.
// - E3 clearance comes 10 to 255 UI after signal returns.
// - DS3 combined loss is analog state OR digital state.
// - DS3 analog thresholds 22/90mV with equalizer, 17/70mV without.
// - STS-1 analog thresholds 25/115mV with equalizer, 20/90mV without.
// - Threshold choice follows threshold select pin and equalizer enable.
// - Digital detector declares after 160 consecutive zero bits.
// - Digital clear needs four straight 32-bit windows of at least ten ones each.
// - Status register read-only: lock, loss, analog, digital, monitor.
// - Analog status bit is 1 exactly while analog loss is declared.
// - Digital status bit is 1 exactly while digital loss is declared.
// - Detector config bit D2 set disables and clears analog detector.
// - Detector config bit D1 set disables and clears digital detector.
// - Both detectors disabled means loss is never declared.
// - Enabled mute forces both data outputs low during loss.
// - Muted channel resumes data by itself once loss clears.
// - Hardware mode: global mute pin high mutes all channels.
// - Host mode: receive config bit D3 enables mute per channel.
// - Data and clock go out single-rail or dual-rail as configured.
// - Loss pin high and status bit 1 on declare, both low on clear.
// - Dual-rail data update on recovered clock rise unless inverted.
// - Single-rail keeps the negative-rail output low continuously.
`timescale 1ns/1ps
`default_nettype none

module los_monitor_mute
	import los_pkg::*;
#(
	parameter int NUM_CH = 3,
	parameter int E3_LOS_UI = E3_LOS_UI_DEF
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	input wire logic host_mode,
	input wire logic global_mute_enable_pin,
	input wire logic threshold_select_pin,
	input wire line_in_t [NUM_CH-1:0] line_in,
	output rx_out_t [NUM_CH-1:0] rx_out,
	output logic [NUM_CH-1:0] loss_of_signal_flag,
	output thr_sel_t [NUM_CH-1:0] threshold_sel
);

	// ==========================================================
	// Elaboration checks
	generate
		if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
			$error("NUM_CH must be 1 to 4");
		end
		if (E3_LOS_UI < E3_LOS_UI_MIN ||
			E3_LOS_UI > E3_LOS_UI_MAX) begin : g_bad_ui
			$error("E3_LOS_UI must lie within 10 to 255");
		end
	endgenerate

	localparam logic [7:0] E3_LAST = 8'(E3_LOS_UI - 1);
	localparam logic [7:0] ZERO_LAST = 8'(ZERO_RUN - 1);
	localparam logic [4:0] WIN_LAST = 5'(WIN_BITS - 1);
	localparam logic [5:0] ONES_MIN = 6'(WIN_ONES);
	localparam logic [2:0] PASS_LAST = 3'(WIN_PASS - 1);

	// ==========================================================
	// Shared pin synchronisers
	logic host_s1_ff;
	logic host_s2_ff;
	logic gmute_s1_ff;
	logic gmute_s2_ff;
	logic thr_s1_ff;
	logic thr_s2_ff;

	always_ff @(posedge clk_sys) begin
		host_s1_ff <= host_mode;
		host_s2_ff <= host_s1_ff;
		gmute_s1_ff <= global_mute_enable_pin;
		gmute_s2_ff <= gmute_s1_ff;
		thr_s1_ff <= threshold_select_pin;
		thr_s2_ff <= thr_s1_ff;
	end

	// ==========================================================
	// Register access decode
	wire [1:0] reg_sel = addr[1:0];
	wire [1:0] ch_sel = addr[3:2];
	wire ch_valid = 32'(ch_sel) < NUM_CH;
	logic [3:0][CFG_W-1:0] ch_words [NUM_CH];

	wire [CFG_W-1:0] rd_word = ch_valid ? ch_words[ch_sel][reg_sel] : '0;
	logic [DATA_W-1:0] rd_data_ff;

	// Reads only sample live state, nothing is cleared
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= rd_en ? DATA_W'(rd_word) : '0;
		end
	end

	assign rd_data = rd_data_ff;

	// ==========================================================
	// Per-channel supervisor
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			line_in_t s1_ff;
			line_in_t s2_ff;
			logic clk_s3_ff;
			logic [CFG_W-1:0] det_cfg_ff;
			logic [CFG_W-1:0] rx_cfg_ff;
			line_mode_t mode_ff;
			logic alos_ff;
			logic nxt_alos;
			logic [7:0] e3_cnt_ff;
			logic [7:0] nxt_e3_cnt;
			dig_state_t dig_ff;
			dig_state_t nxt_dig;
			logic [7:0] zero_cnt_ff;
			logic [7:0] nxt_zero_cnt;
			logic [4:0] win_bit_ff;
			logic [4:0] nxt_win_bit;
			logic [5:0] ones_ff;
			logic [5:0] nxt_ones;
			logic [2:0] pass_ff;
			logic [2:0] nxt_pass;
			logic los_ff;
			logic pos_out_ff;
			logic neg_out_ff;
			logic clk_out_ff;
			thr_sel_t thr_ff;

			always_ff @(posedge clk_sys) begin
				s1_ff <= line_in[ch];
				s2_ff <= s1_ff;
				clk_s3_ff <= s2_ff.line_clk;
			end

			wire rise = s2_ff.line_clk & ~clk_s3_ff;
			wire fall = ~s2_ff.line_clk & clk_s3_ff;
			wire line_bit = s2_ff.pos | s2_ff.neg;

			wire hit = wr_en && ch_sel == 2'(ch);
			wire wr_det = hit && reg_sel == REG_DET_CFG;
			wire wr_rx = hit && reg_sel == REG_RX_CFG;
			wire wr_mode = hit && reg_sel == REG_LINE_MODE;

			wire a_dis = det_cfg_ff[DET_ADIS];
			wire d_dis = det_cfg_ff[DET_DDIS];
			wire eq_on = det_cfg_ff[DET_EQ];
			wire single = rx_cfg_ff[RX_SINGLE];
			wire rx_off = rx_cfg_ff[RX_OFF];
			wire inv = rx_cfg_ff[RX_INV];
			wire is_e3 = mode_ff == MODE_E3;

			// ==================================================
			// Configuration registers, host writes only
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					det_cfg_ff <= CFG_RESET;
					rx_cfg_ff <= CFG_RESET;
					mode_ff <= MODE_E3;
				end else begin
					if (wr_det) begin
						det_cfg_ff <= wr_data[CFG_W-1:0];
					end
					if (wr_rx) begin
						rx_cfg_ff <= wr_data[CFG_W-1:0];
					end
					if (wr_mode) begin
						mode_ff <= line_mode_t'(wr_data[1:0]);
					end
				end
			end

			// ==================================================
			// Analog detector
			// Comparators trip at the levels that threshold_sel picks
			wire persist = alos_ff ? s2_ff.amp_high : s2_ff.amp_low;

			always_comb begin
				nxt_alos = alos_ff;
				nxt_e3_cnt = e3_cnt_ff;
				if (a_dis || rx_off) begin
					nxt_alos = 1'b0;
					nxt_e3_cnt = '0;
				end else if (is_e3) begin
					// Fixed UI delay sits inside the 10..255 span
					if (rise) begin
						if (!persist) begin
							nxt_e3_cnt = '0;
						end else if (e3_cnt_ff == E3_LAST) begin
							nxt_alos = ~alos_ff;
							nxt_e3_cnt = '0;
						end else begin
							nxt_e3_cnt = e3_cnt_ff + 8'h01;
						end
					end
				end else begin
					nxt_e3_cnt = '0;
					// Declare wins if both comparators disagree
					if (s2_ff.amp_low) begin
						nxt_alos = 1'b1;
					end else if (s2_ff.amp_high) begin
						nxt_alos = 1'b0;
					end
				end
			end

			// ==================================================
			// Digital detector, counts recovered bits
			wire [5:0] ones_sum = ones_ff + {5'h00, line_bit};

			always_comb begin
				nxt_dig = dig_ff;
				nxt_zero_cnt = zero_cnt_ff;
				nxt_win_bit = win_bit_ff;
				nxt_ones = ones_ff;
				nxt_pass = pass_ff;
				if (d_dis || rx_off || is_e3) begin
					nxt_dig = DIG_CLEAR;
					nxt_zero_cnt = '0;
					nxt_win_bit = '0;
					nxt_ones = '0;
					nxt_pass = '0;
				end else if (rise) begin
					case (dig_ff)
						DIG_CLEAR: begin
							if (line_bit) begin
								nxt_zero_cnt = '0;
							end else if (zero_cnt_ff == ZERO_LAST) begin
								nxt_dig = DIG_LOSS;
								nxt_zero_cnt = '0;
								nxt_win_bit = '0;
								nxt_ones = '0;
								nxt_pass = '0;
							end else begin
								nxt_zero_cnt = zero_cnt_ff + 8'h01;
							end
						end
						DIG_LOSS: begin
							nxt_win_bit = win_bit_ff + 5'h01;
							nxt_ones = ones_sum;
							if (win_bit_ff == WIN_LAST) begin
								nxt_ones = '0;
								// A thin window throws away earlier passes
								if (ones_sum < ONES_MIN) begin
									nxt_pass = '0;
								end else if (pass_ff == PASS_LAST) begin
									nxt_dig = DIG_CLEAR;
									nxt_pass = '0;
								end else begin
									nxt_pass = pass_ff + 3'h1;
								end
							end
						end
						default: begin
							nxt_dig = DIG_CLEAR;
						end
					endcase
				end
			end

			wire nxt_dlos = nxt_dig == DIG_LOSS;
			wire nxt_los = nxt_alos | nxt_dlos;

			always_ff @(posedge clk_sys) begin
				if (reset) begin
					alos_ff <= 1'b0;
					e3_cnt_ff <= '0;
				end else begin
					alos_ff <= nxt_alos;
					e3_cnt_ff <= nxt_e3_cnt;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (reset) begin
					dig_ff <= DIG_CLEAR;
					zero_cnt_ff <= '0;
					win_bit_ff <= '0;
					ones_ff <= '0;
					pass_ff <= '0;
				end else begin
					dig_ff <= nxt_dig;
					zero_cnt_ff <= nxt_zero_cnt;
					win_bit_ff <= nxt_win_bit;
					ones_ff <= nxt_ones;
					pass_ff <= nxt_pass;
				end
			end

			// Both disabled keeps both terms at zero
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					los_ff <= 1'b0;
				end else begin
					los_ff <= nxt_los;
				end
			end

			wire dlos = dig_ff == DIG_LOSS;

			// ==================================================
			// Mute and delivery to the terminal equipment
			wire mute_en = host_s2_ff ? rx_cfg_ff[RX_MUTE] : gmute_s2_ff;
			// Next loss value, so the declaring edge is blanked too
			wire mute = mute_en & nxt_los;
			wire out_edge = inv ? fall : rise;
			wire pos_src = single ? line_bit : s2_ff.pos;

			always_ff @(posedge clk_sys) begin
				if (reset) begin
					pos_out_ff <= 1'b0;
					neg_out_ff <= 1'b0;
					clk_out_ff <= 1'b0;
				end else begin
					clk_out_ff <= ~rx_off & (s2_ff.line_clk ^ inv);
					if (rx_off || mute) begin
						// Released on the next edge after loss ends
						pos_out_ff <= 1'b0;
						neg_out_ff <= 1'b0;
					end else begin
						if (out_edge) begin
							pos_out_ff <= pos_src;
						end
						if (single) begin
							neg_out_ff <= 1'b0;
						end else if (out_edge) begin
							neg_out_ff <= s2_ff.neg;
						end
					end
				end
			end

			// ==================================================
			// Threshold hand-off
			// Front end reads this to pick its comparator levels
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					thr_ff <= '0;
				end else begin
					thr_ff.sts1 <= mode_ff == MODE_STS1;
					thr_ff.eq_on <= eq_on;
					thr_ff.thr_pin <= thr_s2_ff;
				end
			end

			// ==================================================
			// Outputs and register words
			assign rx_out[ch].positive_rail_data_out = pos_out_ff;
			assign rx_out[ch].negative_rail_data_out = neg_out_ff;
			assign rx_out[ch].recovered_clock_out = clk_out_ff;
			assign loss_of_signal_flag[ch] = los_ff;
			assign threshold_sel[ch] = thr_ff;

			// Live status word, no write path exists
			assign ch_words[ch][REG_STATUS] = {s2_ff.loss_of_lock, los_ff,
				alos_ff, dlos, s2_ff.drive_mon};
			assign ch_words[ch][REG_DET_CFG] = det_cfg_ff;
			assign ch_words[ch][REG_RX_CFG] = rx_cfg_ff;
			assign ch_words[ch][REG_LINE_MODE] = {3'h0, mode_ff};
		end
	endgenerate

endmodule

`default_nettype wire

// >>> testbench/los_monitor_mute_properties.sv
// Port-level checks of the loss-of-signal supervisor.
// Assumes one clk_sys domain with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module los_monitor_mute_properties
	import los_pkg::*;
#(
	parameter int NUM_CH = 3,
	parameter int E3_LOS_UI = E3_LOS_UI_DEF
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic host_mode,
	input wire logic global_mute_enable_pin,
	input wire logic threshold_select_pin,
	input wire line_in_t [NUM_CH-1:0] line_in,
	input wire rx_out_t [NUM_CH-1:0] rx_out,
	input wire logic [NUM_CH-1:0] loss_of_signal_flag,
	input wire thr_sel_t [NUM_CH-1:0] threshold_sel
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ========
	// Register port
	a_rd_quiet: assert property (
		!rd_en |=> rd_data == 8'h00) else $error("stray read data");
	a_rd_top: assert property (
		rd_data[7:5] == 3'h0) else $error("unused read bits set");
	a_unmapped_zero: assert property (
		rd_en && addr[3:2] == 2'h3 |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_status_los: assert property (
		rd_en && addr == 4'h0 |=> rd_data[ST_LOS] ==
		$past(loss_of_signal_flag[0])) else $error("status loss bit");
	a_status_lol: assert property (
		$stable(line_in[0].loss_of_lock)[*4] ##0 rd_en && addr == 4'h0
		|=> rd_data[ST_LOL] == $past(line_in[0].loss_of_lock))
		else $error("status lock bit");
	a_status_mon: assert property (
		$stable(line_in[0].drive_mon)[*4] ##0 rd_en && addr == 4'h0
		|=> rd_data[ST_DMO] == $past(line_in[0].drive_mon))
		else $error("status monitor bit");
	// ========
	// Line side
	a_thr_pin: assert property (
		$stable(threshold_select_pin)[*5] |->
		threshold_sel[0].thr_pin == threshold_select_pin)
		else $error("threshold pin not passed on");
	a_mute_pin: assert property (
		(!host_mode && global_mute_enable_pin)[*4] ##0
		loss_of_signal_flag[0] |-> !rx_out[0].positive_rail_data_out
		&& !rx_out[0].negative_rail_data_out) else $error("not muted");
	c_loss: cover property ($rose(loss_of_signal_flag[0]));
	c_mute: cover property (global_mute_enable_pin && loss_of_signal_flag[0]);
	c_status: cover property (rd_en && addr == 4'h0);
endmodule

bind los_monitor_mute los_monitor_mute_properties #(.NUM_CH(NUM_CH),
	.E3_LOS_UI(E3_LOS_UI)) u_props (.clk_sys(clk_sys), .reset(reset),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .host_mode(host_mode),
	.global_mute_enable_pin(global_mute_enable_pin),
	.threshold_select_pin(threshold_select_pin), .line_in(line_in),
	.rx_out(rx_out), .loss_of_signal_flag(loss_of_signal_flag),
	.threshold_sel(threshold_sel));
`default_nettype wire

// >>> testbench/line_source.sv
// Far-end line model: recovered clock, AMI rails, amplitude flags.
// Assumes the bench shares one source across all channels.
`timescale 1ns/1ps
`default_nettype none
module line_source
	import los_pkg::*;
(
	input wire logic run,
	input wire logic ones,
	input wire logic amp_low,
	input wire logic amp_high,
	input wire logic lol,
	output line_in_t line_out
);
	logic clk_ff = 1'b0;
	logic mark_ff = 1'b0;
	logic pos_ff = 1'b0;
	logic neg_ff = 1'b0;
	// ========
	// Link clock, 160 ns, skewed off clk_sys; still when not running
	initial begin
		#7;
		forever begin
			#80;
			clk_ff = run ? ~clk_ff : 1'b0;
		end
	end
	// Marks alternate so both rails carry traffic
	always @(negedge clk_ff) begin
		pos_ff <= ones & ~mark_ff;
		neg_ff <= ones & mark_ff;
		mark_ff <= mark_ff ^ ones;
	end
	assign line_out = {clk_ff, pos_ff, neg_ff, amp_low, amp_high, lol, lol};
endmodule
`default_nettype wire

// >>> testbench/los_monitor_mute_test.sv
// Self-checking bench for the loss-of-signal supervisor.
// Assumes all channels see the same line source.
`timescale 1ns/1ps
`default_nettype none
module los_monitor_mute_test;
	import los_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic host_mode = 1'b1;
	logic gmute = 1'b0;
	logic thr = 1'b0;
	logic run = 1'b0;
	logic ones = 1'b1;
	logic alow = 1'b0;
	logic ahigh = 1'b1;
	logic lol = 1'b0;
	logic [7:0] rd_data;
	logic [2:0] flag;
	logic [3:0] seen;
	line_in_t src;
	rx_out_t [2:0] rx;
	thr_sel_t [2:0] tsel;
	wire [7:0] clk0_out = {7'h00, rx[0].recovered_clock_out};
	wire [7:0] clk1_inv = {7'h00, ~rx[1].recovered_clock_out};
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	always #10 clk_sys = ~clk_sys;
	los_monitor_mute #(.E3_LOS_UI(10)) i_dut (.clk_sys(clk_sys),
		.reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .host_mode(host_mode),
		.global_mute_enable_pin(gmute), .threshold_select_pin(thr),
		.line_in({3{src}}), .rx_out(rx), .loss_of_signal_flag(flag),
		.threshold_sel(tsel));
	line_source i_src (.run(run), .ones(ones), .amp_low(alow),
		.amp_high(ahigh), .lol(lol), .line_out(src));
	// ========
	// Access and compare tasks
	task automatic chk(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		chk("rd_data", rd_data, e);
	endtask
	task automatic wf(input logic e, input int lim);
		for (int i = 0; i < lim && flag[0] !== e; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk("loss flag", {7'h00, flag[0]}, {7'h00, e});
	endtask
	task automatic hold(input int n, input logic e);
		repeat (n) @(posedge clk_sys);
		#1;
		chk("held flag", {7'h00, flag[0]}, {7'h00, e});
	endtask
	task automatic watch(input int n);
		seen = 4'h0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			seen = seen | {rx[1].positive_rail_data_out,
				rx[1].negative_rail_data_out,
				rx[0].positive_rail_data_out,
				rx[0].negative_rail_data_out};
		end
	endtask
	task automatic sig(input logic lost);
		alow <= lost;
		ahigh <= ~lost;
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard, well above the longest sequence
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end
	// ========
	// Sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		run <= 1'b1;
		rd(4'h1, 8'h00);
		wr(4'h0, 8'h1F);
		rd(4'h0, 8'h00);
		rd(4'h0, 8'h00);
		rd(4'hC, 8'h00);
		lol <= 1'b1;
		sig(1'b1);
		hold(60, 1'b0);
		wf(1'b1, 1900);
		rd(4'h0, 8'h1D);
		lol <= 1'b0;
		alow <= 1'b0;
		hold(300, 1'b1);
		ahigh <= 1'b1;
		hold(60, 1'b1);
		wf(1'b0, 1900);
		host_mode <= 1'b0;
		gmute <= 1'b1;
		sig(1'b1);
		wf(1'b1, 1900);
		watch(200);
		chk("hw mute", {4'h0, seen}, 8'h00);
		sig(1'b0);
		wf(1'b0, 1900);
		watch(100);
		chk("resume", {4'h0, seen}, 8'h0F);
		host_mode <= 1'b1;
		wr(4'h2, 8'h08);
		sig(1'b1);
		wf(1'b1, 1900);
		watch(100);
		chk("host mute", {4'h0, seen}, 8'h0C);
		sig(1'b0);
		wf(1'b0, 1900);
		wr(4'h2, 8'h10);
		watch(100);
		chk("single rail", {4'h0, seen}, 8'h0E);
		wr(4'h3, 8'h01);
		ones <= 1'b0;
		hold(1000, 1'b0);
		wf(1'b1, 500);
		rd(4'h0, 8'h0A);
		ones <= 1'b1;
		hold(990, 1'b1);
		wf(1'b0, 200);
		sig(1'b1);
		wf(1'b1, 40);
		rd(4'h0, 8'h0C);
		sig(1'b0);
		wf(1'b0, 40);
		wr(4'h1, 8'h06);
		ones <= 1'b0;
		sig(1'b1);
		hold(1800, 1'b0);
		rd(4'h0, 8'h00);
		wr(4'h1, 8'h05);
		hold(1000, 1'b0);
		wf(1'b1, 500);
		rd(4'h0, 8'h0A);
		thr <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("thr sel", {5'h00, tsel[0]}, 8'h03);
		wr(4'h3, 8'h02);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("thr sel", {5'h00, tsel[0]}, 8'h07);
		// Channel 1 stays plain, so it is the uninverted reference
		ones <= 1'b1;
		wr(4'h2, 8'h02);
		repeat (4) @(posedge clk_sys);
		repeat (40) begin
			@(posedge clk_sys);
			#1;
			chk("clk invert", clk0_out, clk1_inv);
		end
		wr(4'h2, 8'h04);
		hold(3, 1'b0);
		watch(50);
		chk("rx off", {4'h0, seen}, 8'h0C);
		chk("off clock", clk0_out, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
